//--- ppol_pkg.sv
// Summary of operation
// - Braking ramp limit comes from the deceleration ceiling, preset at reset.
// - Sixteen-bit option word resets to one; only documented fields act.
// - Relative reference applies only when control bit 6 commands relative.
// - Code 00 adds to previous target, zero when none exists.
// - Code 01 adds to the ramp generator output.
// - Code 10 adds to actual position; 11 reserved.
// - Auto release clears new-setpoint and drops setpoint acknowledge in the same cycle.
// - Code 00 leaves clearing new-setpoint to the master.
// - Code 01 clears new-setpoint once the move reaches target.
// - Code 10 clears new-setpoint as soon as it is accepted; 11 reserved.
// - Direction 00 is linear with wrap at range limits.
// - Direction 01 moves only negative, through the minimum limit.
// - Direction 10 moves only positive, through the maximum limit.
// - Direction 11 takes the shorter way around the circle.
// - Following error is a signed 32-bit read-only value, reset zero.
package ppol_pkg;
  localparam logic [15:0] PPOL_IDX_ACCEL   = 16'h60c5;
  localparam logic [15:0] PPOL_IDX_DECEL   = 16'h60c6;
  localparam logic [15:0] PPOL_IDX_OPTION  = 16'h60f2;
  localparam logic [15:0] PPOL_IDX_FOLLOW  = 16'h60f4;
  localparam logic [31:0] PPOL_RST_ACCEL   = 32'h00001388;
  localparam logic [31:0] PPOL_RST_DECEL   = 32'h00001388;
  localparam logic [15:0] PPOL_RST_OPTION  = 16'h0001;
  localparam logic [31:0] PPOL_RST_FOLLOW  = 32'h00000000;
  localparam int          PPOL_REL_LSB     = 0;
  localparam int          PPOL_REL_POS     = 2;
  localparam int          PPOL_DIR_LSB     = 6;
  localparam logic [15:0] PPOL_OPT_MASK    = 16'h00cf;
  localparam logic [1:0]  PPOL_CODE_RSVD   = 2'h3;

  typedef enum logic [1:0] {
    PPOL_REL_TARGET = 2'b00,
    PPOL_REL_RAMP   = 2'b01,
    PPOL_REL_ACTUAL = 2'b10
  } ppol_rel_t;

  typedef enum logic [1:0] {
    PPOL_REQ_MASTER = 2'b00,
    PPOL_REQ_ARRIVE = 2'b01,
    PPOL_REQ_ASAP   = 2'b10
  } ppol_req_t;

  typedef enum logic [1:0] {
    PPOL_DIR_LINEAR = 2'b00,
    PPOL_DIR_NEG    = 2'b01,
    PPOL_DIR_POS    = 2'b10,
    PPOL_DIR_SHORT  = 2'b11
  } ppol_dir_t;

  typedef enum logic [1:0] {
    PPOL_SP_IDLE  = 2'b00,
    PPOL_SP_ACKED = 2'b01,
    PPOL_SP_DROP  = 2'b10
  } ppol_sp_t;

  // Sum used for every relative target base
  function automatic logic [31:0] ppol_add(input logic [31:0] a, input logic [31:0] b);
    ppol_add = a + b;
  endfunction : ppol_add
endpackage : ppol_pkg

//--- ppol_opt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ppol_opt_if;
  import ppol_pkg::*;
  ppol_rel_t rel_sel;
  ppol_req_t req_sel;
  ppol_dir_t dir_sel;
  modport src (output rel_sel, output req_sel, output dir_sel);
  modport dst (input rel_sel, input req_sel, input dir_sel);
endinterface : ppol_opt_if
`default_nettype wire

//--- ppol_option_decode.sv
`timescale 1ns/10ps
`default_nettype none
module ppol_option_decode
  import ppol_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic opt_wr,
  input  wire logic [15:0] opt_wdata,
  ppol_opt_if.src   sel
);
  ppol_rel_t rel_ff;
  ppol_req_t req_ff;
  ppol_dir_t dir_ff;
  wire logic [1:0] rel_code = opt_wdata[PPOL_REL_LSB +: 2];
  wire logic [1:0] req_code = opt_wdata[PPOL_REL_POS +: 2];
  wire logic [1:0] dir_code = opt_wdata[PPOL_DIR_LSB +: 2];
  wire logic rel_ok = opt_wr && (rel_code != PPOL_CODE_RSVD);
  wire logic req_ok = opt_wr && (req_code != PPOL_CODE_RSVD);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rel_ff <= ppol_rel_t'(PPOL_RST_OPTION[1:0]);
      req_ff <= ppol_req_t'(PPOL_RST_OPTION[3:2]);
      dir_ff <= ppol_dir_t'(PPOL_RST_OPTION[7:6]);
    end else begin
      if (rel_ok) rel_ff <= ppol_rel_t'(rel_code);
      if (req_ok) req_ff <= ppol_req_t'(req_code);
      if (opt_wr) dir_ff <= ppol_dir_t'(dir_code);
    end
  end

  assign sel.rel_sel = rel_ff;
  assign sel.req_sel = req_ff;
  assign sel.dir_sel = dir_ff;
endmodule : ppol_option_decode
`default_nettype wire

//--- ppol_profile_position.sv
`timescale 1ns/10ps
`default_nettype none
module ppol_profile_position
  import ppol_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        obj_wr,
  input  wire logic [15:0] obj_index,
  input  wire logic [31:0] obj_wdata,
  output logic      [31:0] obj_rdata,
  output logic             obj_hit,
  input  wire logic        ctrl_new_setpoint,
  input  wire logic        ctrl_relative,
  input  wire logic        move_accept,
  input  wire logic        target_reached,
  input  wire logic [31:0] target_position,
  input  wire logic [31:0] ramp_output,
  input  wire logic [31:0] actual_position,
  input  wire logic [31:0] demand_position,
  input  wire logic [31:0] range_min,
  input  wire logic [31:0] range_max,
  output logic             new_setpoint_clear,
  output logic             setpoint_ack,
  output logic      [31:0] abs_target,
  output logic             target_load,
  output logic      [31:0] accel_limit,
  output logic      [31:0] decel_limit,
  output logic             dir_positive,
  output logic             wrap_via_min,
  output logic             wrap_via_max,
  output logic      [31:0] demand_wrapped
);
  logic [31:0] accel_ff;
  logic [31:0] decel_ff;
  logic [15:0] option_ff;
  logic [31:0] follow_ff;
  logic [31:0] target_ff;
  logic        load_ff;
  logic        ack_ff;
  logic        clr_ff;
  ppol_sp_t    sp_ff;
  ppol_sp_t    nxt_sp;

  ppol_opt_if sel_if ();

  wire logic wr_accel  = obj_wr && (obj_index == PPOL_IDX_ACCEL);
  wire logic wr_decel  = obj_wr && (obj_index == PPOL_IDX_DECEL);
  wire logic wr_option = obj_wr && (obj_index == PPOL_IDX_OPTION);

  ppol_option_decode u_decode (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .opt_wr    (wr_option),
    .opt_wdata (obj_wdata[15:0]),
    .sel       (sel_if.src)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      accel_ff  <= PPOL_RST_ACCEL;
      decel_ff  <= PPOL_RST_DECEL;
      option_ff <= PPOL_RST_OPTION;
    end else begin
      if (wr_accel) accel_ff <= obj_wdata;
      if (wr_decel) decel_ff <= obj_wdata;
      if (wr_option) option_ff <= obj_wdata[15:0] & PPOL_OPT_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) follow_ff <= PPOL_RST_FOLLOW;
    else follow_ff <= demand_position - actual_position;
  end

  // Object readback mux
  always_comb begin
    obj_hit   = 1'b1;
    obj_rdata = 32'h00000000;
    case (obj_index)
      PPOL_IDX_ACCEL:  obj_rdata = accel_ff;
      PPOL_IDX_DECEL:  obj_rdata = decel_ff;
      PPOL_IDX_OPTION: obj_rdata = {16'h0000, option_ff};
      PPOL_IDX_FOLLOW: obj_rdata = follow_ff;
      default:         obj_hit = 1'b0;
    endcase
  end

  // Relative base selection
  logic [31:0] rel_base;
  always_comb begin
    case (sel_if.rel_sel)
      PPOL_REL_TARGET: rel_base = target_ff;
      PPOL_REL_RAMP:   rel_base = ramp_output;
      PPOL_REL_ACTUAL: rel_base = actual_position;
      default:         rel_base = target_ff;
    endcase
  end

  wire logic [31:0] new_target = ctrl_relative ? ppol_add(rel_base, target_position)
                                               : target_position;
  wire logic        take_sp    = ctrl_new_setpoint && move_accept && (sp_ff == PPOL_SP_IDLE);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      target_ff <= 32'h00000000;
      load_ff   <= 1'b0;
    end else begin
      load_ff <= take_sp;
      if (take_sp) target_ff <= new_target;
    end
  end

  // Setpoint handshake
  always_comb begin
    nxt_sp = sp_ff;
    case (sp_ff)
      PPOL_SP_IDLE: begin
        if (take_sp) nxt_sp = PPOL_SP_ACKED;
      end
      PPOL_SP_ACKED: begin
        case (sel_if.req_sel)
          PPOL_REQ_ASAP:   nxt_sp = PPOL_SP_DROP;
          PPOL_REQ_ARRIVE: if (target_reached) nxt_sp = PPOL_SP_DROP;
          default:         if (!ctrl_new_setpoint) nxt_sp = PPOL_SP_IDLE;
        endcase
      end
      PPOL_SP_DROP: begin
        if (!ctrl_new_setpoint) nxt_sp = PPOL_SP_IDLE;
      end
      default: nxt_sp = PPOL_SP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sp_ff  <= PPOL_SP_IDLE;
      ack_ff <= 1'b0;
      clr_ff <= 1'b0;
    end else begin
      sp_ff  <= nxt_sp;
      ack_ff <= (nxt_sp == PPOL_SP_ACKED);
      clr_ff <= (nxt_sp == PPOL_SP_DROP);
    end
  end

  // Direction strategy
  wire logic [31:0] span      = range_max - range_min;
  wire logic [31:0] fwd_dist  = (abs_target >= actual_position) ? (abs_target - actual_position)
                                                                : (abs_target - actual_position + span);
  wire logic        tgt_above = $signed(abs_target) > $signed(actual_position);
  always_comb begin
    dir_positive = tgt_above;
    wrap_via_min = 1'b0;
    wrap_via_max = 1'b0;
    case (sel_if.dir_sel)
      PPOL_DIR_NEG: begin
        dir_positive = 1'b0;
        wrap_via_min = tgt_above;
      end
      PPOL_DIR_POS: begin
        dir_positive = 1'b1;
        wrap_via_max = (abs_target != actual_position) && !tgt_above;
      end
      PPOL_DIR_SHORT: begin
        dir_positive = fwd_dist < {1'b0, span[31:1]};
        wrap_via_max = dir_positive && !tgt_above;
        wrap_via_min = !dir_positive && tgt_above;
      end
      default: dir_positive = tgt_above;
    endcase
  end

  logic [31:0] wrap_ff;
  always_ff @(posedge ref_clk) begin
    if (srst) wrap_ff <= 32'h00000000;
    else if (sel_if.dir_sel == PPOL_DIR_LINEAR && $signed(demand_position) >= $signed(range_max))
      wrap_ff <= range_min;
    else if (sel_if.dir_sel == PPOL_DIR_LINEAR && $signed(demand_position) <= $signed(range_min))
      wrap_ff <= range_max;
    else wrap_ff <= demand_position;
  end

  assign new_setpoint_clear = clr_ff;
  assign setpoint_ack       = ack_ff;
  assign abs_target         = target_ff;
  assign target_load        = load_ff;
  assign accel_limit        = accel_ff;
  assign decel_limit        = decel_ff;
  assign demand_wrapped     = wrap_ff;
endmodule : ppol_profile_position
`default_nettype wire

//--- ppol_profile_position_props.sv
`timescale 1ns/10ps
`default_nettype none
module ppol_props_chk
  import ppol_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [31:0] obj_wdata,
  input wire logic [31:0] obj_rdata,
  input wire logic        ctrl_new_setpoint,
  input wire logic        move_accept,
  input wire logic [31:0] demand_position,
  input wire logic [31:0] actual_position,
  input wire logic        new_setpoint_clear,
  input wire logic        setpoint_ack,
  input wire logic        target_load,
  input wire logic [31:0] decel_limit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [31:0] err_ff;
  logic        dec_wr;
  logic        take;
  assign dec_wr = obj_wr && obj_index == PPOL_IDX_DECEL;
  assign take   = ctrl_new_setpoint && move_accept && !setpoint_ack && !new_setpoint_clear;
  always_ff @(posedge ref_clk) begin
    err_ff <= srst ? 32'h0 : demand_position - actual_position;
  end
  decel_load_a: assert property (dec_wr |=> decel_limit == $past(obj_wdata))
    else $error("decel ceiling missed a write");
  decel_keep_a: assert property (!dec_wr |=> $stable(decel_limit))
    else $error("decel ceiling changed unasked");
  opt_mask_a: assert property (obj_index == PPOL_IDX_OPTION |-> !(obj_rdata & 32'hffffff30))
    else $error("unsupported option bit set");
  err_read_a: assert property (obj_index == PPOL_IDX_FOLLOW |-> obj_rdata == err_ff)
    else $error("following error readback wrong");
  take_ack_a: assert property (take |=> setpoint_ack && target_load)
    else $error("setpoint not acknowledged");
  clear_hold_a: assert property (new_setpoint_clear && ctrl_new_setpoint |=> new_setpoint_clear)
    else $error("release dropped early");
  clear_end_a: assert property (new_setpoint_clear && !ctrl_new_setpoint |=> !new_setpoint_clear)
    else $error("release held too long");
  ack_low_a: assert property (new_setpoint_clear |-> !setpoint_ack)
    else $error("ack high during release");
endmodule : ppol_props_chk
bind ppol_profile_position ppol_props_chk u_chk (
  .ref_clk            (ref_clk),
  .srst               (srst),
  .obj_wr             (obj_wr),
  .obj_index          (obj_index),
  .obj_wdata          (obj_wdata),
  .obj_rdata          (obj_rdata),
  .ctrl_new_setpoint  (ctrl_new_setpoint),
  .move_accept        (move_accept),
  .demand_position    (demand_position),
  .actual_position    (actual_position),
  .new_setpoint_clear (new_setpoint_clear),
  .setpoint_ack       (setpoint_ack),
  .target_load        (target_load),
  .decel_limit        (decel_limit)
);
`default_nettype wire

//--- ppol_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppol_master_model (
  input  wire logic        ref_clk,
  input  wire logic        setpoint_ack,
  input  wire logic        new_setpoint_clear,
  output logic             obj_wr,
  output logic      [15:0] obj_index,
  output logic      [31:0] obj_wdata,
  output logic             ctrl_new_setpoint,
  output logic             ctrl_relative
);
  initial {obj_wr, obj_index, obj_wdata, ctrl_new_setpoint, ctrl_relative} = '0;
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    @(posedge ref_clk) #1;
    {obj_wr, obj_index, obj_wdata} = {1'b1, i, d};
    @(posedge ref_clk) #1;
    obj_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] i);
    @(posedge ref_clk) #1;
    obj_index = i;
  endtask : rd
  task automatic sp(input logic rel, input logic own, output logic ok);
    int n;
    @(posedge ref_clk) #1;
    {ctrl_new_setpoint, ctrl_relative} = {1'b1, rel};
    for (n = 0; n < 50 && !(own ? new_setpoint_clear : setpoint_ack); n++) @(posedge ref_clk) #1;
    ok = n < 50;
    if (own) @(posedge ref_clk) #1;
    ctrl_new_setpoint = 1'b0;
    repeat (3) @(posedge ref_clk) #1;
  endtask : sp
endmodule : ppol_master_model
`default_nettype wire

//--- ppol_profile_position_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ppol_profile_position_tb_top;
  import ppol_pkg::*;
  logic        ref_clk, srst, obj_wr, obj_hit, ctrl_new_setpoint, ctrl_relative;
  logic        move_accept, target_reached, new_setpoint_clear, setpoint_ack;
  logic        target_load, dir_positive, wrap_via_min, wrap_via_max;
  logic [15:0] obj_index;
  logic [31:0] obj_wdata, obj_rdata, target_position, ramp_output, actual_position;
  logic [31:0] demand_position, range_min, range_max, abs_target, accel_limit;
  logic [31:0] decel_limit, demand_wrapped, d, prev;
  logic        ok;
  logic [31:0] exp_q[$];
  logic [31:0] dopt[4] = '{32'h80, 32'h40, 32'hc0, 32'hc0};
  logic [31:0] dtgt[4] = '{32'h64, 32'h384, 32'h64, 32'h384};
  logic        dexp[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic        dmax[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  logic        dmin[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int          num_errors = 0;
  int          samples_checked = 0;
  ppol_profile_position uut (
    .ref_clk            (ref_clk),
    .srst               (srst),
    .obj_wr             (obj_wr),
    .obj_index          (obj_index),
    .obj_wdata          (obj_wdata),
    .obj_rdata          (obj_rdata),
    .obj_hit            (obj_hit),
    .ctrl_new_setpoint  (ctrl_new_setpoint),
    .ctrl_relative      (ctrl_relative),
    .move_accept        (move_accept),
    .target_reached     (target_reached),
    .target_position    (target_position),
    .ramp_output        (ramp_output),
    .actual_position    (actual_position),
    .demand_position    (demand_position),
    .range_min          (range_min),
    .range_max          (range_max),
    .new_setpoint_clear (new_setpoint_clear),
    .setpoint_ack       (setpoint_ack),
    .abs_target         (abs_target),
    .target_load        (target_load),
    .accel_limit        (accel_limit),
    .decel_limit        (decel_limit),
    .dir_positive       (dir_positive),
    .wrap_via_min       (wrap_via_min),
    .wrap_via_max       (wrap_via_max),
    .demand_wrapped     (demand_wrapped)
  );
  ppol_master_model m (
    .ref_clk            (ref_clk),
    .setpoint_ack       (setpoint_ack),
    .new_setpoint_clear (new_setpoint_clear),
    .obj_wr             (obj_wr),
    .obj_index          (obj_index),
    .obj_wdata          (obj_wdata),
    .ctrl_new_setpoint  (ctrl_new_setpoint),
    .ctrl_relative      (ctrl_relative)
  );
  always #10 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic rdc(input logic [15:0] i, input logic [31:0] e);
    m.rd(i);
    @(negedge ref_clk);
    chk("rdata", obj_rdata, e);
  endtask : rdc
  task automatic wrapc(input logic [31:0] dp, input logic [31:0] e);
    @(posedge ref_clk) #1;
    demand_position = dp;
    repeat (2) @(negedge ref_clk);
    chk("wrapped", demand_wrapped, e);
  endtask : wrapc
  task automatic move(input logic rel, input logic own, input logic [31:0] base);
    logic ok;
    target_position = $urandom;
    prev = rel ? base + target_position : target_position;
    exp_q.push_back(prev);
    m.sp(rel, own, ok);
    chk("handshake", ok, 32'h1);
    if (!ok) tally_and_finish();
  endtask : move
  always @(negedge ref_clk) begin
    if (target_load === 1'b1 && exp_q.size() == 0) chk("load", 32'h1, 32'h0);
    else if (target_load === 1'b1) chk("target", abs_target, exp_q.pop_front());
  end
  initial begin
    #2000000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {ref_clk, srst, move_accept, target_reached} = 4'b0110;
    {target_position, ramp_output, actual_position, demand_position} = '0;
    {range_min, range_max} = {32'h0, 32'h3e8};
    void'($urandom(32'h58bd1466));
    repeat (16) @(posedge ref_clk);
    #1 srst = 1'b0;
    rdc(16'h60c5, 32'h1388);
    rdc(16'h60c6, 32'h1388);
    rdc(16'h60f2, 32'h1);
    rdc(16'h60f4, 32'h0);
    rdc(16'h6502, 32'h0);
    chk("hit", obj_hit, 32'h0);
    d = $urandom;
    m.wr(16'h60c6, d);
    rdc(16'h60c6, d);
    chk("decel", decel_limit, d);
    m.wr(16'h60c5, ~d);
    rdc(16'h60c5, ~d);
    chk("accel", accel_limit, ~d);
    @(posedge ref_clk) #1;
    {demand_position, actual_position} = {$urandom, $urandom};
    m.wr(16'h60f4, d);
    rdc(16'h60f4, demand_position - actual_position);
    m.wr(16'h60f2, 32'h0);
    move(1'b1, 1'b0, 32'h0);
    move(1'b1, 1'b0, prev);
    m.wr(16'h60f2, 32'h9);
    ramp_output = $urandom;
    move(1'b1, 1'b1, ramp_output);
    move(1'b0, 1'b1, 32'h0);
    m.wr(16'h60f2, 32'ha);
    m.wr(16'h60f2, 32'hffff);
    rdc(16'h60f2, 32'hcf);
    move(1'b1, 1'b1, actual_position);
    m.wr(16'h60f2, 32'h4);
    target_reached = 1'b0;
    fork
      move(1'b1, 1'b1, prev);
      begin
        repeat (8) @(posedge ref_clk);
        #1 chk("early release", new_setpoint_clear, 32'h0);
        target_reached = 1'b1;
      end
    join
    wrapc(32'h3e8, 32'h0);
    wrapc(32'h0, 32'h3e8);
    wrapc(32'h100, 32'h100);
    @(posedge ref_clk) #1;
    actual_position = 32'h200;
    foreach (dopt[i]) begin
      m.wr(16'h60f2, dopt[i]);
      target_position = dtgt[i];
      exp_q.push_back(dtgt[i]);
      m.sp(1'b0, 1'b0, ok);
      chk("handshake", ok, 32'h1);
      @(negedge ref_clk);
      chk("direction", dir_positive, dexp[i]);
      chk("via max", wrap_via_max, dmax[i]);
      chk("via min", wrap_via_min, dmin[i]);
    end
    chk("pending", exp_q.size(), 32'h0);
    tally_and_finish();
  end
endmodule : ppol_profile_position_tb_top
`default_nettype wire
